// *** verilog/rbs_boot_select.sv ***
// Reset-time boot selection: strap sampling, flash control, start address
//
// How it works
// [RQ1] At reset release the boot space enable flag copies the boot jump bit.
// [RQ2] At reset release check strobe low, external access high, latch high.
// [RQ3] Forced boot loads flash control 00h and start address F800h.
// [RQ4] Forced boot starts the bootloader whatever the boot jump bit says.
// [RQ5] No forced boot loads flash control with F0h.
// [RQ6] No forced boot and jump bit 1 starts the user code at 0000h.
// [RQ7] No forced boot and jump bit 0 starts the bootloader at F800h.
// [RQ8] A stored vector byte gives the user bootloader high address byte.
// [RQ9] Vector byte defaults to FFh, meaning no user bootloader exists.
// [RQ10] Shipped parts hold the boot jump bit at 0.
// [RQ11] The boot jump bit is written only while programming routines run.
// [RQ12] Boot space overlays F800h to FFFFh only during routine calls.
// [RQ13] Otherwise the full 64 KB code range is user flash.
// [RQ14] The board presents straps before release and may drop them after.
// [RQ15] The board stops driving the strobe pin after reset release.
// [RQ16] The board never grounds the strobe pin during power-on.
// [RQ17] Straps and jump bit are captured once after release and held.
`timescale 1ns/100ps
`include "rbs_params.svh"
module rbs_boot_select (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic nv_por_i,
    input wire logic ce_i,
    input wire logic prog_store_strobe_n_i,
    input wire logic external_access_i,
    input wire logic addr_latch_strobe_i,
    input wire logic api_active_i,
    input wire logic wr_jump_i,
    input wire logic wr_jump_val_i,
    input wire logic wr_vec_i,
    input wire logic [7:0] wr_vec_val_i,
    input wire logic flash_control_reg_wr_i,
    input wire logic [7:0] flash_control_reg_wdata_i,
    input wire logic aux_wr_i,
    input wire logic [7:0] aux_wdata_i,
    input wire logic [15:0] code_addr_i,
    output logic boot_done_o,
    output logic forced_boot_o,
    output logic boot_space_enable_o,
    output logic [7:0] aux_control_reg_o,
    output logic [7:0] flash_control_reg_o,
    output logic [15:0] start_pc_o,
    output logic start_in_boot_o,
    output logic boot_jump_select_o,
    output logic [7:0] user_boot_vector_byte_o,
    output logic user_boot_present_o,
    output logic [15:0] user_boot_addr_o,
    output logic code_from_boot_o
);
    // True when an address falls in the window the boot space may overlay
    function automatic logic in_boot_window(input logic [15:0] addr);
        in_boot_window = (addr >= `RBS_BOOT_BASE) && (addr <= `RBS_BOOT_TOP);
    endfunction

    rbs_pkg::rbs_strap_t strap_raw;
    rbs_pkg::rbs_strap_t strap_sync;
    logic strap_stable;
    logic jump_bit;
    logic [7:0] vec_byte;

    rbs_pkg::rbs_state_t state;
    rbs_pkg::rbs_state_t next_state;
    rbs_pkg::rbs_boot_cfg_t cfg;
    rbs_pkg::rbs_boot_cfg_t next_cfg;

    assign strap_raw.prog_store_strobe_n = prog_store_strobe_n_i;
    assign strap_raw.external_access = external_access_i;
    assign strap_raw.addr_latch_strobe = addr_latch_strobe_i;

    // Straps come from pins: three flops, count once stages two and three agree
    rbs_sync3 #(
        .WIDTH(3)
    ) u_strap_sync (
        .sys_clk_i(sys_clk_i),
        .ce_i(ce_i),
        .async_i(strap_raw),
        .sync_o(strap_sync),
        .stable_o(strap_stable)
    );

    rbs_cfg_store u_cfg_store (
        .sys_clk_i(sys_clk_i),
        .nv_por_i(nv_por_i),
        .ce_i(ce_i),
        .api_active_i(api_active_i),
        .wr_jump_i(wr_jump_i),
        .wr_jump_val_i(wr_jump_val_i),
        .wr_vec_i(wr_vec_i),
        .wr_vec_val_i(wr_vec_val_i),
        .boot_jump_select_o(jump_bit),
        .user_boot_vector_byte_o(vec_byte)
    );

    // An unconnected latch strobe pin is pulled high on the board side
    wire forced_now = !strap_sync.prog_store_strobe_n // [RQ2]
        && strap_sync.external_access
        && strap_sync.addr_latch_strobe;

    // One capture only, and only once the synchronised straps have settled
    wire capture = (state == rbs_pkg::RBS_ST_CAPTURE) && strap_stable; // [RQ17]

    wire boot_sel = forced_now || !jump_bit; // [RQ4] [RQ7]

    always_comb begin
        next_cfg.forced = forced_now;
        next_cfg.mode = boot_sel ? rbs_pkg::RBS_MODE_BOOT
                                 : rbs_pkg::RBS_MODE_USER;
        next_cfg.flash_control = forced_now ? `RBS_FLASH_CONTROL_REG_FORCED // [RQ3]
                                            : `RBS_FLASH_CONTROL_REG_NORMAL; // [RQ5]
        next_cfg.start_pc = boot_sel ? `RBS_PC_BOOT // [RQ3] [RQ7]
                                     : `RBS_PC_USER; // [RQ6]
    end

    always_comb begin
        next_state = state;
        unique case (state)
            rbs_pkg::RBS_ST_CAPTURE: begin
                if (capture) begin
                    next_state = rbs_pkg::RBS_ST_RUN;
                end
            end
            rbs_pkg::RBS_ST_RUN: begin
                next_state = rbs_pkg::RBS_ST_RUN;
            end
            default: begin
                next_state = rbs_pkg::RBS_ST_CAPTURE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= rbs_pkg::RBS_ST_CAPTURE;
        end else if (ce_i) begin
            state <= next_state;
        end
    end

    // Captured values stay put until the next reset
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg <= '0;
        end else if (ce_i && capture) begin
            cfg <= next_cfg; // [RQ17]
        end
    end

    wire running = (state == rbs_pkg::RBS_ST_RUN);
    wire flash_control_reg_we = ce_i && running && flash_control_reg_wr_i;
    wire aux_we = ce_i && running && aux_wr_i;
    wire [7:0] aux_boot_space_enable_mask = 8'h01 << `RBS_AUX_BOOT_SPACE_ENABLE_BIT;

    // Software can rewrite flash control once running; capture sets it first
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            flash_control_reg_o <= `RBS_FLASH_CONTROL_REG_RESET;
        end else if (ce_i && capture) begin
            flash_control_reg_o <= next_cfg.flash_control; // [RQ3] [RQ5]
        end else if (flash_control_reg_we) begin
            flash_control_reg_o <= flash_control_reg_wdata_i;
        end
    end

    // Enable flag is hardware-owned; software writes leave that bit alone
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            aux_control_reg_o <= `RBS_AUX_RESET;
        end else if (ce_i && capture) begin
            aux_control_reg_o[`RBS_AUX_BOOT_SPACE_ENABLE_BIT] <= jump_bit; // [RQ1]
        end else if (aux_we) begin
            aux_control_reg_o <= (aux_wdata_i & ~aux_boot_space_enable_mask)
                | (aux_control_reg_o & aux_boot_space_enable_mask);
        end
    end

    // Boot space overlays the top window only during routine calls
    wire boot_fetch = api_active_i && in_boot_window(code_addr_i); // [RQ12]

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            boot_done_o <= 1'b0;
            forced_boot_o <= 1'b0;
            boot_space_enable_o <= 1'b0;
            start_pc_o <= `RBS_PC_USER;
            start_in_boot_o <= 1'b0;
            boot_jump_select_o <= `RBS_BOOT_JUMP_SELECT_SHIP;
            user_boot_vector_byte_o <= `RBS_SBV_DEFAULT;
            user_boot_present_o <= 1'b0;
            user_boot_addr_o <= {`RBS_SBV_DEFAULT, `RBS_VEC_LOW};
            code_from_boot_o <= 1'b0;
        end else if (ce_i) begin
            boot_done_o <= running || capture;
            if (capture) begin
                forced_boot_o <= next_cfg.forced;
                boot_space_enable_o <= jump_bit; // [RQ1]
                start_pc_o <= next_cfg.start_pc;
                start_in_boot_o <= in_boot_window(next_cfg.start_pc);
            end
            boot_jump_select_o <= jump_bit;
            user_boot_vector_byte_o <= vec_byte;
            user_boot_present_o <= (vec_byte != `RBS_SBV_NONE); // [RQ9]
            user_boot_addr_o <= {vec_byte, `RBS_VEC_LOW}; // [RQ8]
            // Outside calls every address, top window too, is user flash
            code_from_boot_o <= boot_fetch; // [RQ13]
        end
    end
endmodule // rbs_boot_select

// *** verilog/rbs_params.svh ***
// Constants for the reset-time boot selection block
`ifndef RBS_PARAMS_SVH
`define RBS_PARAMS_SVH
`define RBS_FLASH_CONTROL_REG_FORCED 8'h00
`define RBS_FLASH_CONTROL_REG_NORMAL 8'hf0
`define RBS_FLASH_CONTROL_REG_RESET 8'hf0
`define RBS_PC_BOOT 16'hf800
`define RBS_PC_USER 16'h0000
`define RBS_BOOT_BASE 16'hf800
`define RBS_BOOT_TOP 16'hffff
`define RBS_SBV_DEFAULT 8'hff
`define RBS_SBV_NONE 8'hff
`define RBS_BOOT_JUMP_SELECT_SHIP 1'b0
`define RBS_AUX_BOOT_SPACE_ENABLE_BIT 5
`define RBS_AUX_RESET 8'h00
`define RBS_VEC_LOW 8'h00
`endif

// *** verilog/rbs_pkg.sv ***
// Types shared by the boot selection files
package rbs_pkg;
    typedef struct packed {
        logic prog_store_strobe_n;
        logic external_access;
        logic addr_latch_strobe;
    } rbs_strap_t;

    typedef enum logic [1:0] {
        RBS_ST_CAPTURE = 2'b00,
        RBS_ST_RUN = 2'b01
    } rbs_state_t;

    typedef enum logic {
        RBS_MODE_USER = 1'b0,
        RBS_MODE_BOOT = 1'b1
    } rbs_mode_t;

    typedef struct packed {
        logic forced;
        rbs_mode_t mode;
        logic [7:0] flash_control;
        logic [15:0] start_pc;
    } rbs_boot_cfg_t;
endpackage

// *** verilog/rbs_sync3.sv ***
// Three-stage synchroniser with agreement flag for strap pins
`timescale 1ns/100ps
module rbs_sync3 #(
    parameter int WIDTH = 3
) (
    input wire logic sys_clk_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o,
    output logic stable_o
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // No reset: the chain must already hold the strap levels at release
    always_ff @(posedge sys_clk_i) begin
        if (ce_i) begin
            stage1 <= async_i;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    assign sync_o = stage3;
    assign stable_o = (stage2 == stage3);
endmodule // rbs_sync3

// *** verilog/rbs_cfg_store.sv ***
// Non-volatile boot jump bit and user boot vector byte
`timescale 1ns/100ps
`include "rbs_params.svh"
module rbs_cfg_store (
    input wire logic sys_clk_i,
    input wire logic nv_por_i,
    input wire logic ce_i,
    input wire logic api_active_i,
    input wire logic wr_jump_i,
    input wire logic wr_jump_val_i,
    input wire logic wr_vec_i,
    input wire logic [7:0] wr_vec_val_i,
    output logic boot_jump_select_o,
    output logic [7:0] user_boot_vector_byte_o
);
    wire jump_we = ce_i && api_active_i && wr_jump_i; // [RQ11]
    wire vec_we = ce_i && api_active_i && wr_vec_i; // [RQ11]

    // Cleared only by the power-on event, never by the system reset
    always_ff @(posedge sys_clk_i or posedge nv_por_i) begin
        if (nv_por_i) begin
            boot_jump_select_o <= `RBS_BOOT_JUMP_SELECT_SHIP; // [RQ10]
            user_boot_vector_byte_o <= `RBS_SBV_DEFAULT; // [RQ9]
        end else begin
            if (jump_we) begin
                boot_jump_select_o <= wr_jump_val_i;
            end
            if (vec_we) begin
                user_boot_vector_byte_o <= wr_vec_val_i; // [RQ8]
            end
        end
    end
endmodule // rbs_cfg_store

// *** test/rbs_boot_select_asserts.sv ***
// Concurrent checks on the boot selection block ports
`timescale 1ns/100ps
module rbs_boot_select_asserts (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic prog_store_strobe_n_i,
    input wire logic external_access_i,
    input wire logic addr_latch_strobe_i,
    input wire logic api_active_i,
    input wire logic wr_jump_i,
    input wire logic [15:0] code_addr_i,
    input wire logic boot_done_o,
    input wire logic forced_boot_o,
    input wire logic boot_space_enable_o,
    input wire logic [7:0] flash_control_reg_o,
    input wire logic [15:0] start_pc_o,
    input wire logic boot_jump_select_o,
    input wire logic code_from_boot_o
);
    logic cond;
    assign cond = !prog_store_strobe_n_i && external_access_i
        && addr_latch_strobe_i;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    AST_CAPTURE: assert property ($fell(rst_i) |=> boot_done_o)
        else $error("capture missed");
    AST_ENABLE: assert property ($rose(boot_done_o) |->
        boot_space_enable_o == boot_jump_select_o) else $error("enable");
    AST_FORCED: assert property ($rose(boot_done_o) |->
        forced_boot_o == $past(cond)) else $error("forced");
    AST_FLASH_CONTROL_REG: assert property ($rose(boot_done_o) |->
        flash_control_reg_o == (forced_boot_o ? 8'h00 : 8'hf0))
        else $error("flash_control_reg");
    AST_PC: assert property ($rose(boot_done_o) |->
        start_pc_o ==
        (forced_boot_o || !boot_space_enable_o ? 16'hf800 : 16'h0000))
        else $error("start address");
    AST_HOLD: assert property (boot_done_o && $past(boot_done_o) |->
        $stable({forced_boot_o, boot_space_enable_o, start_pc_o}))
        else $error("capture not held");
    AST_JUMP_LOCK: assert property (boot_done_o && $past(boot_done_o)
        && $changed(boot_jump_select_o) |-> $past(wr_jump_i && api_active_i, 2))
        else $error("jump bit changed without routine write");
    AST_MAP: assert property (api_active_i && code_addr_i >= 16'hf800
        |=> code_from_boot_o) else $error("boot space not mapped");
    cover property ($rose(boot_done_o) && forced_boot_o);
    cover property ($rose(boot_done_o) && start_pc_o == 16'h0000);
    cover property (code_from_boot_o);
endmodule // rbs_boot_select_asserts

bind rbs_boot_select rbs_boot_select_asserts u_chk (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .prog_store_strobe_n_i(prog_store_strobe_n_i),
    .external_access_i(external_access_i), .api_active_i(api_active_i),
    .addr_latch_strobe_i(addr_latch_strobe_i), .wr_jump_i(wr_jump_i),
    .code_addr_i(code_addr_i), .boot_done_o(boot_done_o),
    .forced_boot_o(forced_boot_o), .boot_space_enable_o(boot_space_enable_o),
    .flash_control_reg_o(flash_control_reg_o), .start_pc_o(start_pc_o),
    .boot_jump_select_o(boot_jump_select_o),
    .code_from_boot_o(code_from_boot_o));

// *** test/rbs_strap_model.sv ***
// Board strap drivers seen by the boot selection block around reset
`timescale 1ns/100ps
module rbs_strap_model (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic nv_por_i,
    input wire rbs_pkg::rbs_strap_t strap_i,
    output rbs_pkg::rbs_strap_t pins_o
);
    logic [1:0] since = 2'h0;
    logic wiggle = 1'b0;
    always @(posedge sys_clk_i or posedge rst_i)
        if (rst_i) since <= 2'h0;
        else if (since != 2'h3) since <= since + 2'h1;
    // Released strobe pin belongs to the device, so it shows no stale level
    always @(negedge sys_clk_i)
        wiggle <= ~wiggle;
    always_comb begin
        pins_o = strap_i;
        if (nv_por_i) pins_o.prog_store_strobe_n = 1'b1;
        else if (since > 2'h1) pins_o.prog_store_strobe_n = wiggle;
    end
endmodule // rbs_strap_model

// *** test/reset_boot_select_bench.sv ***
// Self-checking bench for the reset-time boot selection block
`timescale 1ns/100ps
module reset_boot_select_bench;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, nv = 1'b1, api = 1'b0;
    logic wj = 1'b0, wjv = 1'b0, wv = 1'b0, jbit = 1'b0;
    logic done, forced, en, sib, jb, pres, cfb;
    logic [7:0] wvv = 8'h00, vb = 8'hff, aux, flash_control_reg, vec;
    logic [15:0] addr = 16'h0000, pc, uba;
    rbs_pkg::rbs_strap_t strap = 3'h7, pins;
    rbs_pkg::rbs_boot_cfg_t cfg;
    int fail_count = 0, checks_done = 0;
    rbs_boot_select uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .nv_por_i(nv),
        .ce_i(1'b1), .prog_store_strobe_n_i(pins.prog_store_strobe_n),
        .external_access_i(pins.external_access), .api_active_i(api),
        .addr_latch_strobe_i(pins.addr_latch_strobe), .wr_jump_i(wj),
        .wr_jump_val_i(wjv), .wr_vec_i(wv), .wr_vec_val_i(wvv),
        .flash_control_reg_wr_i(1'b0), .flash_control_reg_wdata_i(8'h00), .aux_wr_i(1'b0),
        .aux_wdata_i(8'h00), .code_addr_i(addr), .boot_done_o(done),
        .forced_boot_o(forced), .boot_space_enable_o(en),
        .aux_control_reg_o(aux), .flash_control_reg_o(flash_control_reg),
        .start_pc_o(pc), .start_in_boot_o(sib), .boot_jump_select_o(jb),
        .user_boot_vector_byte_o(vec), .user_boot_present_o(pres),
        .user_boot_addr_o(uba), .code_from_boot_o(cfb));
    rbs_strap_model board (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .nv_por_i(nv), .strap_i(strap), .pins_o(pins));
    initial forever #4 sys_clk_i = ~sys_clk_i;
    task automatic chk(string nm, logic [25:0] e, logic [25:0] g);
        checks_done++;
        fail_count += int'(g !== e);
        if (g !== e) $display("[ERR] %s expected %h seen %h", nm, e, g);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic boot(logic [2:0] s);
        logic f, b;
        strap = s;
        rst_i = 1'b1;
        // Synchroniser needs three edges of stable straps before release
        repeat (4) @(negedge sys_clk_i);
        {nv, rst_i} = 2'h0;
        @(negedge sys_clk_i);
        f = !s[2] && s[1] && s[0];
        b = f || !jbit;
        cfg = {f, b, f ? 8'h00 : 8'hf0, b ? 16'hf800 : 16'h0000};
        chk("cfg", cfg, {forced, sib, flash_control_reg, pc});
        chk("enable", {jbit, jbit, 1'b1}, {aux[5], en, done});
        strap = 3'($urandom);
        repeat (3) @(negedge sys_clk_i);
        chk("held", cfg, {forced, sib, flash_control_reg, pc});
    endtask
    task automatic wr(logic a, logic j, logic [7:0] v);
        {api, wj, wjv, wv, wvv} = {a, 1'b1, j, 1'b1, v};
        @(negedge sys_clk_i);
        {api, wj, wv} = 3'h0;
        if (a) {jbit, vb} = {j, v};
        repeat (2) @(negedge sys_clk_i);
        chk("jump", jbit, jb);
        chk("vector", {vb, vb != 8'hff, vb, 8'h00}, {vec, pres, uba});
    endtask
    initial begin
        void'($urandom(32'h7e97));
        boot(3'h7);
        wr(1'b0, 1'b1, 8'h12);
        $display("shipped state done");
        for (int i = 0; i < 16; i++) begin
            wr(1'b1, i[3], 8'($urandom));
            boot(i[2:0]);
        end
        $display("strap and jump sweep done");
        for (int i = 0; i < 40; i++) begin
            api = 1'($urandom);
            addr = i < 4 ? 16'hf7fe + 16'(i) : 16'($urandom);
            @(negedge sys_clk_i);
            chk("map", api && addr >= 16'hf800, cfb);
        end
        $display("code map done");
        summarize;
    end
    initial begin
        // Tests need well under a thousand cycles
        #100000;
        fail_count++;
        summarize;
    end
endmodule // reset_boot_select_bench
